// ### core/adcc_pkg.sv
// package: register map, field positions, reset values and timing constants of the converter control
package adcc_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_TRIG = 8'h04;
   localparam logic [7:0] OFF_CHAN = 8'h08;
   localparam logic [7:0] OFF_PORT = 8'h0C;
   localparam logic [7:0] OFF_RESULT = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFF_REFCTL = 8'h1C;
   localparam logic [7:0] OFF_DAC0 = 8'h20;
   localparam logic [7:0] OFF_DAC1 = 8'h24;
   localparam logic [7:0] OFF_DACMODE = 8'h28;
   localparam int MODE_START_BIT = 7;
   localparam int MODE_SCAN_BIT = 6;
   localparam int MODE_ENABLE_BIT = 0;
   localparam int TRIG_TIMER_BIT = 7;
   localparam int TRIG_SINGLE_BIT = 0;
   localparam int REF_BOOST_BIT = 1;
   localparam int REF_OUT_EN_BIT = 0;
   localparam int REF_SRC_SEL_BIT = 3;
   localparam int DACM_REF_SEL_BIT = 6;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_DACREJ_BIT = 1;
   localparam int CHAN_W = 4;
   localparam int RES_W = 12;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [31:0] RESP_OKAY = 32'h0;
   localparam logic [1:0] BRESP_OKAY = 2'h0;
   localparam logic [1:0] BRESP_SLVERR = 2'h2;
   localparam int CLK_MHZ = 250;
   localparam int CONV_CYCLES = 64;
endpackage

// ### core/adcc_sar.sv
// successive-approximation sequencer producing one 12-bit code per conversion
`timescale 1ns/1ps
module adcc_sar
   import adcc_pkg::*;
#(
   parameter int RES_BITS = RES_W,
   parameter int CYCLES = CONV_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_run,
   input wire logic i_restart,
   input wire logic i_cmp,
   output logic [RES_BITS-1:0] o_code,
   output logic o_done
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt_q, cnt_d;
   logic [RES_BITS-1:0] code_q, code_d;
   logic done_q, done_d;
   // the comparator is stepped at the tail of each conversion, one bit per cycle
   always_comb begin
      cnt_d = cnt_q;
      code_d = code_q;
      done_d = 1'b0;
      if (!i_run || i_restart) begin
         cnt_d = '0;
         code_d = '0;
      end else if (cnt_q == CW'(CYCLES - 1)) begin
         cnt_d = '0;
         done_d = 1'b1;
         code_d = {code_q[RES_BITS-2:0], i_cmp};
      end else begin
         cnt_d = cnt_q + CW'(1);
         if (cnt_q >= CW'(CYCLES - 1 - RES_BITS)) begin
            code_d = {code_q[RES_BITS-2:0], i_cmp};
         end
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         cnt_q <= '0;
         code_q <= '0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         code_q <= code_d;
         done_q <= done_d;
      end
   end
   assign o_code = code_q;
   assign o_done = done_q;
endmodule

// ### core/adcc_top.sv
// converter control: register file on AXI4-Lite, conflict handling, flag and interrupt
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module adcc_top
   import adcc_pkg::*;
#(
   parameter int CYCLES = CONV_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_cmp,
   input wire logic i_timer_trig,
   output logic [CHAN_W-1:0] o_channel,
   output logic o_converting,
   output logic o_irq
);
   logic [7:0] mode_q, mode_d, trig_q, trig_d, port_q, port_d, ref_q, ref_d, dacm_q, dacm_d;
   logic [CHAN_W-1:0] chan_q, chan_d;
   logic [RES_W-1:0] result_q, result_d, pend_q, pend_d, dac0_q, dac0_d, dac1_q, dac1_d;
   logic pend_v_q, pend_v_d;
   logic [1:0] stat_q, stat_d, mask_q, mask_d;
   logic awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
   logic [ADDR_W-1:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] br_q, br_d;
   logic irq_q;
   logic [RES_W-1:0] sar_code;
   logic sar_done;
   logic wr_go, rd_go, rd_result, ctl_wr, chan_wr, restart, run, dac_blocked;
   //////////////////////////////////////////////////////////////////////////////
   assign run = mode_q[MODE_ENABLE_BIT] && mode_q[MODE_START_BIT];
   assign wr_go = awh_q && wh_q && !bv_q;
   assign rd_go = i_arvalid && !rv_q;
   assign rd_result = rd_go && (i_araddr == OFF_RESULT);
   assign ctl_wr = wr_go && (awa_q == OFF_MODE || awa_q == OFF_TRIG || awa_q == OFF_CHAN || awa_q == OFF_PORT);
   assign chan_wr = wr_go && (awa_q == OFF_CHAN);
   // single-shot timer-trigger mode does not restart the conversion on a channel write
   assign restart = (chan_wr && !(trig_q[TRIG_TIMER_BIT] && trig_q[TRIG_SINGLE_BIT]))
      || (i_timer_trig && trig_q[TRIG_TIMER_BIT]);
   // shared reference in use by both converters blocks dac writes while the start bit is set, even with enable clear
   assign dac_blocked = ref_q[REF_SRC_SEL_BIT] && dacm_q[DACM_REF_SEL_BIT] && mode_q[MODE_START_BIT];
   adcc_sar #(.RES_BITS(RES_W), .CYCLES(CYCLES)) u_sar (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_run(run),
      .i_restart(restart),
      .i_cmp(i_cmp),
      .o_code(sar_code),
      .o_done(sar_done)
   );
   //////////////////////////////////////////////////////////////////////////////
   always_comb begin
      awh_d = awh_q;
      awa_d = awa_q;
      wh_d = wh_q;
      wd_d = wd_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rd_d = rd_q;
      mode_d = mode_q;
      trig_d = trig_q;
      chan_d = chan_q;
      port_d = port_q;
      ref_d = ref_q;
      dacm_d = dacm_q;
      dac0_d = dac0_q;
      dac1_d = dac1_q;
      mask_d = mask_q;
      stat_d = stat_q;
      result_d = result_q;
      pend_d = pend_q;
      pend_v_d = 1'b0;
      if (i_awvalid && !awh_q) begin
         awh_d = 1'b1;
         awa_d = i_awaddr;
      end
      if (i_wvalid && !wh_q) begin
         wh_d = 1'b1;
         wd_d = i_wdata;
      end
      if (bv_q && i_bready) begin
         bv_d = 1'b0;
      end
      if (rv_q && i_rready) begin
         rv_d = 1'b0;
      end
      // clear first so that an event landing in the same cycle still sets its bit
      if (wr_go && awa_q == OFF_IRQ_STAT) begin
         stat_d = stat_q & ~wd_q[1:0];
      end
      if (pend_v_q) begin
         result_d = pend_q;
         stat_d[STAT_DONE_BIT] = 1'b1;
      end
      if (sar_done) begin
         if (ctl_wr) begin
            result_d = result_q;
         end else if (rd_result) begin
            pend_d = sar_code;
            pend_v_d = 1'b1;
         end else begin
            result_d = sar_code;
            stat_d[STAT_DONE_BIT] = 1'b1;
         end
         if (trig_q[TRIG_TIMER_BIT] && trig_q[TRIG_SINGLE_BIT] && !ctl_wr) begin
            mode_d[MODE_START_BIT] = 1'b0;
         end
      end
      if (i_timer_trig && trig_q[TRIG_TIMER_BIT] && mode_q[MODE_ENABLE_BIT]) begin
         mode_d[MODE_START_BIT] = 1'b1;
      end
      if (wr_go) begin
         awh_d = 1'b0;
         wh_d = 1'b0;
         bv_d = 1'b1;
         br_d = BRESP_OKAY;
         case (awa_q)
            OFF_MODE: mode_d = wd_q[7:0];
            OFF_TRIG: trig_d = wd_q[7:0];
            OFF_CHAN: chan_d = wd_q[CHAN_W-1:0];
            OFF_PORT: port_d = wd_q[7:0];
            OFF_REFCTL: ref_d = wd_q[7:0];
            OFF_DACMODE: dacm_d = wd_q[7:0];
            OFF_IRQ_MASK: mask_d = wd_q[1:0];
            OFF_IRQ_STAT: br_d = BRESP_OKAY;
            OFF_DAC0, OFF_DAC1: begin
               if (dac_blocked) begin
                  br_d = BRESP_SLVERR;
                  stat_d[STAT_DACREJ_BIT] = 1'b1;
               end else if (awa_q == OFF_DAC0) begin
                  dac0_d = wd_q[RES_W-1:0];
               end else begin
                  dac1_d = wd_q[RES_W-1:0];
               end
            end
            OFF_RESULT: br_d = BRESP_OKAY;
            default: br_d = BRESP_SLVERR;
         endcase
      end
      if (rd_go) begin
         rv_d = 1'b1;
         case (i_araddr)
            OFF_MODE: rd_d = {24'h0, mode_q};
            OFF_TRIG: rd_d = {24'h0, trig_q};
            OFF_CHAN: rd_d = {28'h0, chan_q};
            OFF_PORT: rd_d = {24'h0, port_q};
            OFF_RESULT: rd_d = {20'h0, result_q};
            OFF_IRQ_STAT: rd_d = {30'h0, stat_q};
            OFF_IRQ_MASK: rd_d = {30'h0, mask_q};
            OFF_REFCTL: rd_d = {24'h0, ref_q};
            OFF_DAC0: rd_d = {20'h0, dac0_q};
            OFF_DAC1: rd_d = {20'h0, dac1_q};
            OFF_DACMODE: rd_d = {24'h0, dacm_q};
            default: rd_d = RESP_OKAY;
         endcase
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         awh_q <= 1'b0;
         awa_q <= '0;
         wh_q <= 1'b0;
         wd_q <= '0;
         bv_q <= 1'b0;
         br_q <= BRESP_OKAY;
         rv_q <= 1'b0;
         rd_q <= '0;
         mode_q <= MODE_RST;
         trig_q <= MODE_RST;
         chan_q <= '0;
         port_q <= MODE_RST;
         ref_q <= MODE_RST;
         dacm_q <= MODE_RST;
         dac0_q <= '0;
         dac1_q <= '0;
         mask_q <= '0;
         stat_q <= '0;
         result_q <= '0;
         pend_q <= '0;
         pend_v_q <= 1'b0;
         irq_q <= 1'b0;
         o_channel <= '0;
         o_converting <= 1'b0;
      end else begin
         awh_q <= awh_d;
         awa_q <= awa_d;
         wh_q <= wh_d;
         wd_q <= wd_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         mode_q <= mode_d;
         trig_q <= trig_d;
         chan_q <= chan_d;
         port_q <= port_d;
         ref_q <= ref_d;
         dacm_q <= dacm_d;
         dac0_q <= dac0_d;
         dac1_q <= dac1_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         result_q <= result_d;
         pend_q <= pend_d;
         pend_v_q <= pend_v_d;
         irq_q <= |(stat_d & mask_d);
         o_channel <= chan_d;
         o_converting <= mode_d[MODE_ENABLE_BIT] && mode_d[MODE_START_BIT];
      end
   end
   assign o_awready = !awh_q;
   assign o_wready = !wh_q;
   assign o_bvalid = bv_q;
   assign o_bresp = br_q;
   assign o_arready = !rv_q;
   assign o_rvalid = rv_q;
   assign o_rdata = rd_q;
   assign o_rresp = BRESP_OKAY;
   assign o_irq = irq_q;
   //////////////////////////////////////////////////////////////////////////////
   property p_read_first;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (sar_done && rd_result && !ctl_wr) |=> ##1 (stat_q[STAT_DONE_BIT] && result_q == $past(sar_code, 2));
   endproperty
   a_read_first: assert property (p_read_first) else $error("deferred result not stored");
   property p_ctl_drop;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (sar_done && ctl_wr && !pend_v_q) |=> (result_q == $past(result_q));
   endproperty
   a_ctl_drop: assert property (p_ctl_drop) else $error("result stored despite control write");
   property p_chan_keeps_flag;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (chan_wr && stat_q[STAT_DONE_BIT]) |=> stat_q[STAT_DONE_BIT];
   endproperty
   a_chan_keeps_flag: assert property (p_chan_keeps_flag) else $error("channel write cleared flag");
   property p_restart;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (chan_wr && run && !trig_q[TRIG_SINGLE_BIT]) |=> !sar_done;
   endproperty
   a_restart: assert property (p_restart) else $error("conversion not restarted");
   property p_sticky;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (stat_q[STAT_DONE_BIT] && !(wr_go && awa_q == OFF_IRQ_STAT)) |=> stat_q[STAT_DONE_BIT];
   endproperty
   a_sticky: assert property (p_sticky) else $error("done flag dropped");
   property p_store_sets;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (sar_done && !ctl_wr && !rd_result) |=> stat_q[STAT_DONE_BIT];
   endproperty
   a_store_sets: assert property (p_store_sets) else $error("store did not set flag");
   property p_dac_guard;
      @(posedge i_core_clk) disable iff (!i_nrst)
      (wr_go && awa_q == OFF_DAC0 && dac_blocked) |=> (dac0_q == $past(dac0_q) && br_q == BRESP_SLVERR);
   endproperty
   a_dac_guard: assert property (p_dac_guard) else $error("dac rewritten on shared reference");
   property p_width;
      @(posedge i_core_clk) disable iff (!i_nrst)
      rv_q && $past(rd_result) |-> (rd_q[31:RES_W] == 20'h0);
   endproperty
   a_width: assert property (p_width) else $error("result wider than 12 bits");
endmodule

// ### sim/tb_adc_control_conflict_logic.sv
// testbench: register access, conversion, done flag, interrupt and dac interlock checks
`timescale 1ns/1ps
module tb_adc_control_conflict_logic;
   import adcc_pkg::*;
   localparam int CYC = 16;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic cmp = 1'b0;
   logic timer_trig = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, converting, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, s;
   logic [CHAN_W-1:0] channel;
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;
   int t0;
   always #2 core_clk = ~core_clk;
   adcc_top #(.CYCLES(CYC)) dut_u (.i_core_clk(core_clk), .i_nrst(nrst), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
      .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready), .i_cmp(cmp), .i_timer_trig(timer_trig), .o_channel(channel),
      .o_converting(converting), .o_irq(irq));
   //////////////////////////////////////////////////////////////////////////////
   task results;
      if (n_mismatch == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard: the whole sequence needs under a thousand cycles
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         results;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // each channel released at the edge where it was taken; values sampled mid-cycle are stable
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ha, hw, hb;
      logic [1:0] r;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      hb = 1'b0;
      while (!hb) begin
         @(negedge core_clk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid;
         r = bresp;
         @(posedge core_clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
      end
      chk({30'h0, r}, {30'h0, er});
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      logic ha, hr;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      hr = 1'b0;
      while (!hr) begin
         @(negedge core_clk);
         ha = arvalid && arready;
         hr = rvalid;
         d = rdata;
         if (hr) chk({30'h0, rresp}, {30'h0, BRESP_OKAY});
         @(posedge core_clk);
         if (ha) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
      end
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(d, e);
   endtask
   task wait_done;
      for (int i = 0; i < 100; i++) begin
         rd(OFF_IRQ_STAT, s);
         if (s[STAT_DONE_BIT] === 1'b1) break;
      end
   endtask
   //////////////////////////////////////////////////////////////////////////////
   task t_reset;
      rdc(OFF_MODE, 32'h0);
      rdc(OFF_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rdc(8'hFC, 32'h0);
      wr(8'hFC, 32'h5, BRESP_SLVERR);
   endtask
   task t_convert;
      cmp <= 1'b1;
      wr(OFF_IRQ_MASK, 32'h1, BRESP_OKAY);
      wr(OFF_CHAN, 32'h2, BRESP_OKAY);
      wr(OFF_MODE, 32'h01, BRESP_OKAY);
      repeat (CLK_MHZ) @(posedge core_clk);
      wr(OFF_MODE, 32'h81, BRESP_OKAY);
      chk({31'h0, converting}, 32'h1);
      chk({28'h0, channel}, 32'h2);
      wait_done;
      chk(s & 32'h1, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rdc(OFF_RESULT, 32'h0000_0FFF);
      wr(OFF_MODE, 32'h00, BRESP_OKAY);
      wr(OFF_REFCTL, 32'h00, BRESP_OKAY);
      wr(OFF_CHAN, 32'h5, BRESP_OKAY);
      rd(OFF_IRQ_STAT, s);
      chk(s & 32'h1, 32'h1);
      chk({28'h0, channel}, 32'h5);
      wr(OFF_IRQ_MASK, 32'h0, BRESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      wr(OFF_IRQ_MASK, 32'h1, BRESP_OKAY);
      chk({31'h0, irq}, 32'h1);
      wr(OFF_IRQ_STAT, 32'h1, BRESP_OKAY);
      rdc(OFF_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask
   // a channel write half way through must push the done event a full conversion later
   task t_restart;
      cmp <= 1'b0;
      wr(OFF_MODE, 32'h81, BRESP_OKAY);
      repeat (CYC / 2) @(posedge core_clk);
      wr(OFF_CHAN, 32'h3, BRESP_OKAY);
      t0 = cyc;
      chk({28'h0, channel}, 32'h3);
      chk({31'h0, converting}, 32'h1);
      wait_done;
      chk({31'h0, (cyc - t0) >= CYC - 4}, 32'h1);
      rdc(OFF_RESULT, 32'h0);
      wr(OFF_MODE, 32'h00, BRESP_OKAY);
      wr(OFF_IRQ_STAT, 32'h1, BRESP_OKAY);
   endtask
   // done lands CYC edges after a start write returns; reads and writes are aimed at that edge
   task t_conflict;
      cmp <= 1'b1;
      wr(OFF_MODE, 32'h81, BRESP_OKAY);
      repeat (CYC - 2) @(posedge core_clk);
      rdc(OFF_RESULT, 32'h0);
      cmp <= 1'b0;
      rdc(OFF_RESULT, 32'h0000_0FFF);
      rd(OFF_IRQ_STAT, s);
      chk(s & 32'h1, 32'h1);
      wr(OFF_MODE, 32'h00, BRESP_OKAY);
      wr(OFF_IRQ_STAT, 32'h1, BRESP_OKAY);
      wr(OFF_MODE, 32'h81, BRESP_OKAY);
      repeat (CYC - 3) @(posedge core_clk);
      wr(OFF_PORT, 32'h5A, BRESP_OKAY);
      rdc(OFF_RESULT, 32'h0000_0FFF);
      rd(OFF_IRQ_STAT, s);
      chk(s & 32'h1, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rdc(OFF_PORT, 32'h5A);
      wait_done;
      rdc(OFF_RESULT, 32'h0);
      wr(OFF_MODE, 32'h00, BRESP_OKAY);
      wr(OFF_IRQ_STAT, 32'h1, BRESP_OKAY);
   endtask
   // single-shot timer mode: a channel write must not push the done event back
   task t_single;
      wr(OFF_TRIG, 32'h81, BRESP_OKAY);
      wr(OFF_MODE, 32'h01, BRESP_OKAY);
      repeat (CLK_MHZ) @(posedge core_clk);
      timer_trig <= 1'b1;
      @(posedge core_clk);
      timer_trig <= 1'b0;
      t0 = cyc;
      repeat (CYC / 2) @(posedge core_clk);
      chk({31'h0, converting}, 32'h1);
      wr(OFF_CHAN, 32'h6, BRESP_OKAY);
      chk({28'h0, channel}, 32'h6);
      wait_done;
      chk({31'h0, (cyc - t0) < CYC + 10}, 32'h1);
      rdc(OFF_MODE, 32'h01);
      chk({31'h0, converting}, 32'h0);
      wr(OFF_TRIG, 32'h00, BRESP_OKAY);
      wr(OFF_MODE, 32'h00, BRESP_OKAY);
      wr(OFF_IRQ_STAT, 32'h1, BRESP_OKAY);
   endtask
   task t_dac;
      wr(OFF_REFCTL, 32'h08, BRESP_OKAY);
      wr(OFF_DACMODE, 32'h40, BRESP_OKAY);
      wr(OFF_MODE, 32'h81, BRESP_OKAY);
      wr(OFF_DAC0, 32'hABC, BRESP_SLVERR);
      rd(OFF_IRQ_STAT, s);
      chk(s & 32'h2, 32'h2);
      wr(OFF_MODE, 32'h00, BRESP_OKAY);
      rdc(OFF_DAC0, 32'h0);
      wr(OFF_DAC0, 32'h123, BRESP_OKAY);
      rdc(OFF_DAC0, 32'h123);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset;
      t_convert;
      t_restart;
      t_conflict;
      t_single;
      t_dac;
      results;
   end
endmodule
